//--- design/port_pkg.sv
// Summary of operation
// - port 0 is eight pins, each bit's direction bit: 0 input, 1 output.
// - reset clears every port 0 direction bit, all port 0 pins are inputs.
// - external access turns port 0 into the bus and clears its direction bits.
// - bus-mode strap caught at reset: low separate data, high multiplexed address/data.
// - reset clears port 0 and port 1 output latches, pins stay inputs.
// - port 1 function/direction pair: 00 in, 01 out, 10 data byte, 11 address byte.
package port_pkg;

  // ==========================================================
  // register offsets
  localparam logic [31:0] PORT0_LATCH_OFS = 32'hffff_f000;
  localparam logic [31:0] PORT1_LATCH_OFS = 32'hffff_f001;
  localparam logic [31:0] PORT0_DIR_OFS   = 32'hffff_f002;
  localparam logic [31:0] PORT1_DIR_OFS   = 32'hffff_f004;
  localparam logic [31:0] PORT1_FSEL_OFS  = 32'hffff_f005;

  // ==========================================================
  // reset values
  localparam logic [7:0] LATCH_RST = 8'h00;
  localparam logic [7:0] DIR_RST   = 8'h00;
  localparam logic [7:0] FSEL_RST  = 8'h00;
  localparam logic [7:0] RDATA_RST = 8'h00;

  // ==========================================================
  // pin function codes, function bit above direction bit
  localparam logic [1:0] SEL_INPUT  = 2'b00;
  localparam logic [1:0] SEL_OUTPUT = 2'b01;
  localparam logic [1:0] SEL_DATA   = 2'b10;
  localparam logic [1:0] SEL_ADDR   = 2'b11;

  localparam int SYNC_STAGES = 2;

endpackage

//--- design/port_mux_if.sv
`timescale 1ns/100ps

// ==========================================================
// control from register block to one pin multiplexer
interface port_mux_if #(parameter int W = 8);
  logic [2*W-1:0] sel;
  logic [W-1:0]   latch;
  logic [W-1:0]   data_byte;
  logic [W-1:0]   addr_byte;
  logic           data_drive;
  logic [W-1:0]   pin_out;
  logic [W-1:0]   pin_oe;

  modport ctrl (output sel, latch, data_byte, addr_byte, data_drive,
                input  pin_out, pin_oe);
  modport mux  (input  sel, latch, data_byte, addr_byte, data_drive,
                output pin_out, pin_oe);
endinterface

//--- design/sync_2ff.sv
`timescale 1ns/100ps

module sync_2ff
  import port_pkg::*;
#(
  parameter int W = 8
)
(
  input  wire logic         i_ref_clk, // system clock
  input  wire logic [W-1:0] i_async,   // pin level
  output logic      [W-1:0] o_sync     // level after two flops
);

  if (W < 1)
  begin : g_bad_w
    $error("sync_2ff width must be at least one");
  end

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  always_ff @(posedge i_ref_clk)
  begin
    meta_r <= i_async;
    sync_r <= meta_r;
  end

  assign o_sync = sync_r;

endmodule // sync_2ff

//--- design/port_pin_mux.sv
`timescale 1ns/100ps

module port_pin_mux
  import port_pkg::*;
#(
  parameter int W = 8
)
(
  input  wire logic i_ref_clk, // system clock
  input  wire logic i_rst,     // synchronous reset, high
  port_mux_if.mux   mx         // selection and pin drive
);

  if (W < 1)
  begin : g_bad_w
    $error("port_pin_mux width must be at least one");
  end

  logic [W-1:0] out_nxt;
  logic [W-1:0] oe_nxt;
  logic [W-1:0] out_r;
  logic [W-1:0] oe_r;

  // ==========================================================
  // per-bit function decode
  // four-way pin function
  always_comb
  begin
    out_nxt = '0;
    oe_nxt  = '0;
    for (int b = 0; b < W; b++)
    begin
      case (mx.sel[2*b +: 2])
        SEL_OUTPUT:
        begin
          out_nxt[b] = mx.latch[b];
          oe_nxt[b]  = 1'b1;
        end
        SEL_DATA:
        begin
          out_nxt[b] = mx.data_byte[b];
          oe_nxt[b]  = mx.data_drive;
        end
        SEL_ADDR:
        begin
          out_nxt[b] = mx.addr_byte[b];
          oe_nxt[b]  = 1'b1;
        end
        default:
        begin
          out_nxt[b] = 1'b0;
          oe_nxt[b]  = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      out_r <= '0;
      oe_r  <= '0;
    end
    else
    begin
      out_r <= out_nxt;
      oe_r  <= oe_nxt;
    end
  end

  assign mx.pin_out = out_r;
  assign mx.pin_oe  = oe_r;

  // ==========================================================
  // checks
  chk_out_mode_drive:
    assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (mx.sel[1:0] == SEL_OUTPUT) |=> (out_r[0] == $past(mx.latch[0])) && oe_r[0])
    else $error("output mode bit does not drive its latch");

  chk_addr_mode_drive:
    assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (mx.sel[1:0] == SEL_ADDR) |=> (out_r[0] == $past(mx.addr_byte[0])) && oe_r[0])
    else $error("address mode bit does not drive address");

  chk_input_mode_float:
    assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (mx.sel[1:0] == SEL_INPUT) |=> !oe_r[0])
    else $error("input mode bit is driven");

endmodule // port_pin_mux

//--- design/bus_shared_port_pair.sv
// Added by the designer: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps

module bus_shared_port_pair
  import port_pkg::*;
#(
  parameter int PORT_W = 8
)
(
  input  wire logic              i_ref_clk,        // system clock
  input  wire logic              i_rst,            // synchronous reset, high
  input  wire logic [31:0]       i_addr,           // register address
  input  wire logic [7:0]        i_wdata,          // register write data
  input  wire logic              i_wr,             // write strobe
  input  wire logic              i_rd,             // read strobe
  output logic      [7:0]        o_rdata,          // read data, cycle after strobe
  input  wire logic              i_bus_mode_strap, // bus mode strap pin
  output logic                   o_bus_mode,       // 1: multiplexed bus
  input  wire logic [PORT_W-1:0] i_p0_pin,         // port 0 pin levels
  output logic      [PORT_W-1:0] o_p0_out,         // port 0 pin drive value
  output logic      [PORT_W-1:0] o_p0_oe,          // port 0 output enable
  input  wire logic [PORT_W-1:0] i_p1_pin,         // port 1 pin levels
  output logic      [PORT_W-1:0] o_p1_out,         // port 1 pin drive value
  output logic      [PORT_W-1:0] o_p1_oe,          // port 1 output enable
  input  wire logic              i_ext_access,     // external access active
  input  wire logic              i_ext_drive,      // bus drives data pins
  input  wire logic              i_ext_addr_phase, // address phase, mux mode
  input  wire logic [15:0]       i_ext_addr,       // external address low half
  input  wire logic [15:0]       i_ext_wdata,      // external write data
  output logic      [15:0]       o_ext_rdata       // data bus as sampled
);

  if (PORT_W != 8)
  begin : g_bad_w
    $error("bus_shared_port_pair supports eight-bit ports only");
  end

  // ==========================================================
  // helpers
  function automatic logic [2*PORT_W-1:0] pack_sel(input logic [PORT_W-1:0] fsel,
                                                  input logic [PORT_W-1:0] dir);
    logic [2*PORT_W-1:0] s;
    s = '0;
    for (int b = 0; b < PORT_W; b++)
    begin
      s[2*b +: 2] = {fsel[b], dir[b]};
    end
    return s;
  endfunction

  // output bits read back their latch, the rest read the pin
  function automatic logic [7:0] read_merge(input logic [7:0] pin,
                                            input logic [7:0] latch,
                                            input logic [7:0] outmask);
    return (pin & ~outmask) | (latch & outmask);
  endfunction

  // ==========================================================
  // pin and strap synchronisers
  logic [PORT_W-1:0] p0_pin_s;
  logic [PORT_W-1:0] p1_pin_s;
  logic              strap_s;

  sync_2ff #(.W(2*PORT_W)) u_pin_sync (
    .i_ref_clk (i_ref_clk),
    .i_async   ({i_p1_pin, i_p0_pin}),
    .o_sync    ({p1_pin_s, p0_pin_s})
  );

  sync_2ff #(.W(1)) u_strap_sync (
    .i_ref_clk (i_ref_clk),
    .i_async   (i_bus_mode_strap),
    .o_sync    (strap_s)
  );

  // ==========================================================
  // register file
  logic [7:0] p0_latch_r;
  logic [7:0] p1_latch_r;
  logic [7:0] p0_dir_r;
  logic [7:0] p1_dir_r;
  logic [7:0] p1_fsel_r;
  logic       bus_mode_r;
  logic [7:0] rdata_r;
  logic [15:0] ext_rdata_r;

  wire hit_p0_latch = (i_addr == PORT0_LATCH_OFS);
  wire hit_p1_latch = (i_addr == PORT1_LATCH_OFS);
  wire hit_p0_dir   = (i_addr == PORT0_DIR_OFS);
  wire hit_p1_dir   = (i_addr == PORT1_DIR_OFS);
  wire hit_p1_fsel  = (i_addr == PORT1_FSEL_OFS);

  wire [7:0] p1_outmask = p1_dir_r & ~p1_fsel_r;

  logic [7:0] rdata_nxt;
  always_comb
  begin
    if (hit_p0_latch)
      rdata_nxt = read_merge(p0_pin_s, p0_latch_r, p0_dir_r);
    else if (hit_p1_latch)
      rdata_nxt = read_merge(p1_pin_s, p1_latch_r, p1_outmask);
    else if (hit_p0_dir)
      rdata_nxt = p0_dir_r;
    else if (hit_p1_dir)
      rdata_nxt = p1_dir_r;
    else if (hit_p1_fsel)
      rdata_nxt = p1_fsel_r;
    else
      rdata_nxt = RDATA_RST;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      p0_latch_r <= LATCH_RST;
      p1_latch_r <= LATCH_RST;
    end
    else
    begin
      if (i_wr && hit_p0_latch)
        p0_latch_r <= i_wdata;
      if (i_wr && hit_p1_latch)
        p1_latch_r <= i_wdata;
    end
  end

  // external access clears it, over any write
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst || i_ext_access)
      p0_dir_r <= DIR_RST;
    else if (i_wr && hit_p0_dir)
      p0_dir_r <= i_wdata;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      p1_dir_r  <= DIR_RST;
      p1_fsel_r <= FSEL_RST;
    end
    else
    begin
      if (i_wr && hit_p1_dir)
        p1_dir_r <= i_wdata;
      if (i_wr && hit_p1_fsel)
        p1_fsel_r <= i_wdata;
    end
  end

  // strap tracked while reset is held, frozen after
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      bus_mode_r <= strap_s;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      rdata_r     <= RDATA_RST;
      ext_rdata_r <= '0;
    end
    else
    begin
      rdata_r     <= i_rd ? rdata_nxt : RDATA_RST;
      ext_rdata_r <= {p1_pin_s, p0_pin_s};
    end
  end

  // ==========================================================
  // pin multiplexers
  port_mux_if #(.W(PORT_W)) p0_if ();
  port_mux_if #(.W(PORT_W)) p1_if ();

  wire       addr_out   = bus_mode_r && i_ext_addr_phase;
  wire [7:0] p0_bus_byte = addr_out ? i_ext_addr[7:0] : i_ext_wdata[7:0];
  wire [7:0] p1_bus_byte = addr_out ? i_ext_addr[15:8] : i_ext_wdata[15:8];
  wire       bus_drive   = i_ext_drive || addr_out;

  // per-bit direction; whole port on bus during access
  assign p0_if.sel        = pack_sel({PORT_W{i_ext_access}}, p0_dir_r & ~{PORT_W{i_ext_access}});
  assign p0_if.latch      = p0_latch_r;
  assign p0_if.data_byte  = p0_bus_byte;
  assign p0_if.addr_byte  = i_ext_addr[7:0];
  assign p0_if.data_drive = bus_drive;

  // function and direction pair per pin
  assign p1_if.sel        = pack_sel(p1_fsel_r, p1_dir_r);
  assign p1_if.latch      = p1_latch_r;
  assign p1_if.data_byte  = p1_bus_byte;
  assign p1_if.addr_byte  = i_ext_addr[15:8];
  assign p1_if.data_drive = bus_drive;

  port_pin_mux #(.W(PORT_W)) u_p0_mux (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .mx        (p0_if.mux)
  );

  port_pin_mux #(.W(PORT_W)) u_p1_mux (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .mx        (p1_if.mux)
  );

  assign o_p0_out    = p0_if.pin_out;
  assign o_p0_oe     = p0_if.pin_oe;
  assign o_p1_out    = p1_if.pin_out;
  assign o_p1_oe     = p1_if.pin_oe;
  assign o_rdata     = rdata_r;
  assign o_bus_mode  = bus_mode_r;
  assign o_ext_rdata = ext_rdata_r;

  // ==========================================================
  // checks
  sequence s_dir_write;
    i_wr && hit_p0_dir && !i_ext_access;
  endsequence

  sequence s_ext_cycle;
    i_ext_access;
  endsequence

  sequence s_reset_release;
    $fell(i_rst);
  endsequence

  chk_p0_dir_reset:
    assert property (@(posedge i_ref_clk) i_rst |=> (p0_dir_r == DIR_RST))
    else $error("port 0 direction not cleared by reset");

  chk_latch_reset:
    assert property (@(posedge i_ref_clk)
      i_rst |=> (p0_latch_r == LATCH_RST) && (p1_latch_r == LATCH_RST) ##1 (o_p0_oe == '0))
    else $error("latches not cleared or pins driven after reset");

  chk_p1_ctrl_reset:
    assert property (@(posedge i_ref_clk)
      i_rst |=> (p1_dir_r == DIR_RST) && (p1_fsel_r == FSEL_RST))
    else $error("port 1 control not cleared by reset");

  chk_ext_clears_dir:
    assert property (@(posedge i_ref_clk) disable iff (i_rst)
      s_ext_cycle |=> (p0_dir_r == DIR_RST))
    else $error("external access left port 0 direction set");

  chk_p0_dir_write:
    assert property (@(posedge i_ref_clk) disable iff (i_rst)
      s_dir_write ##1 !i_ext_access |=> (o_p0_oe == $past(p0_dir_r)))
    else $error("port 0 enables do not follow direction bits");

  chk_strap_hold:
    assert property (@(posedge i_ref_clk) disable iff (i_rst)
      !$past(i_rst) |-> $stable(bus_mode_r))
    else $error("bus mode changed outside reset");

  chk_mux_addr_out:
    assert property (@(posedge i_ref_clk) disable iff (i_rst)
      i_ext_access && bus_mode_r && i_ext_addr_phase
      |=> (o_p0_out == $past(i_ext_addr[7:0])) && (o_p0_oe == 8'hff))
    else $error("multiplexed address not on port 0");

  chk_read_dir:
    assert property (@(posedge i_ref_clk) disable iff (i_rst)
      i_rd && hit_p0_dir |=> (o_rdata == $past(p0_dir_r)))
    else $error("direction readback wrong");

  chk_strap_capture:
    assert property (@(posedge i_ref_clk)
      s_reset_release |-> (bus_mode_r == $past(strap_s)))
    else $error("bus mode not taken from strap at reset");

  chk_bus_data_drive:
    assert property (@(posedge i_ref_clk) disable iff (i_rst)
      i_ext_access && i_ext_drive && !i_ext_addr_phase
      |=> (o_p0_oe == 8'hff) && (o_p0_out == $past(i_ext_wdata[7:0])))
    else $error("write data not driven on port 0");

  chk_bus_release:
    assert property (@(posedge i_ref_clk) disable iff (i_rst)
      i_ext_access && !i_ext_drive && !i_ext_addr_phase |=> (o_p0_oe == '0))
    else $error("port 0 driven while bus reads");

  chk_p0_latch_out:
    assert property (@(posedge i_ref_clk) disable iff (i_rst)
      !i_ext_access && p0_dir_r[0] |=> o_p0_oe[0] && (o_p0_out[0] == $past(p0_latch_r[0])))
    else $error("port 0 output bit does not drive its latch");

  chk_p1_addr_byte:
    assert property (@(posedge i_ref_clk) disable iff (i_rst)
      p1_fsel_r[0] && p1_dir_r[0] |=> o_p1_oe[0] && (o_p1_out[0] == $past(i_ext_addr[8])))
    else $error("port 1 address bit not driven");

  chk_p1_data_hold:
    assert property (@(posedge i_ref_clk) disable iff (i_rst)
      p1_fsel_r[0] && !p1_dir_r[0] && !i_ext_drive && !i_ext_addr_phase |=> !o_p1_oe[0])
    else $error("port 1 data bit driven with no bus drive");

  chk_p1_mux_addr:
    assert property (@(posedge i_ref_clk) disable iff (i_rst)
      p1_fsel_r[7] && !p1_dir_r[7] && i_ext_access && bus_mode_r && i_ext_addr_phase
      |=> o_p1_oe[7] && (o_p1_out[7] == $past(i_ext_addr[15])))
    else $error("multiplexed address not on port 1");

endmodule // bus_shared_port_pair

//--- testbench/ext_pin_model.sv
`timescale 1ns/100ps

// ==========================================================
// far side of one port: external memory bus and board lines
module ext_pin_model
(
  input  wire logic       i_ref_clk, // system clock
  input  wire logic [7:0] i_oe,      // chip drives pin
  input  wire logic [7:0] i_out,     // chip drive value
  input  wire logic [7:0] i_far,     // level the far device holds
  input  wire logic       i_far_en,  // far device driving
  output logic      [7:0] o_pin      // resolved pin level
);
  logic [7:0] toggle_r = 8'h5a;

  // no pull on these lines: an undriven pin changes every cycle
  always @(posedge i_ref_clk)
  begin
    toggle_r <= ~toggle_r;
  end

  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      o_pin[i] = i_oe[i] ? i_out[i] : (i_far_en ? i_far[i] : toggle_r[i]);
    end
  end
endmodule // ext_pin_model

//--- testbench/test_bus_shared_port_pair.sv
`timescale 1ns/100ps

module test_bus_shared_port_pair;
  import port_pkg::*;
  logic        i_ref_clk = 0, i_rst = 1, wr_s = 0, rd_s = 0, strap = 0;
  logic        acc = 0, drv = 0, aph = 0, far_en = 1;
  logic [31:0] addr = 0, e;
  logic [7:0]  wdat = 0, rdata, far0 = 0, far1 = 0, p0_pin, p1_pin, v;
  logic [7:0]  p0_out, p0_oe, p1_out, p1_oe, l0, l1, d0, d1, fs;
  logic [15:0] ext_addr = 0, ext_wdata = 0, ext_rdata;
  logic        bus_mode;
  int          mismatches = 0, compares = 0;

  always #4 i_ref_clk = ~i_ref_clk;

  bus_shared_port_pair dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(addr),
    .i_wdata(wdat), .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata),
    .i_bus_mode_strap(strap), .o_bus_mode(bus_mode), .i_p0_pin(p0_pin),
    .o_p0_out(p0_out), .o_p0_oe(p0_oe), .i_p1_pin(p1_pin), .o_p1_out(p1_out),
    .o_p1_oe(p1_oe), .i_ext_access(acc), .i_ext_drive(drv), .i_ext_addr_phase(aph),
    .i_ext_addr(ext_addr), .i_ext_wdata(ext_wdata), .o_ext_rdata(ext_rdata));
  ext_pin_model m0 (.i_ref_clk(i_ref_clk), .i_oe(p0_oe), .i_out(p0_out), .i_far(far0),
    .i_far_en(far_en), .o_pin(p0_pin));
  ext_pin_model m1 (.i_ref_clk(i_ref_clk), .i_oe(p1_oe), .i_out(p1_out), .i_far(far1),
    .i_far_en(far_en), .o_pin(p1_pin));

  // ==========================================================
  // expectation and comparison
  function automatic logic [31:0] exp_pins(input logic mux);
    logic [7:0]  oe0, out0, oe1, out1;
    logic        dbus;
    logic [15:0] bv;
    dbus = drv || (mux && aph);
    bv   = (mux && aph) ? ext_addr : ext_wdata;
    oe0  = acc ? {8{dbus}} : d0;
    out0 = acc ? bv[7:0] : l0;
    for (int i = 0; i < 8; i++)
    begin
      case ({fs[i], d1[i]})
        SEL_INPUT:  {oe1[i], out1[i]} = {1'b0, 1'b0};
        SEL_OUTPUT: {oe1[i], out1[i]} = {1'b1, l1[i]};
        SEL_DATA:   {oe1[i], out1[i]} = {dbus, bv[8+i]};
        default:    {oe1[i], out1[i]} = {1'b1, ext_addr[8+i]};
      endcase
    end
    return {oe1, out1 & oe1, oe0, out0 & oe0};
  endfunction

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_pins(input logic mux);
    check("pins", exp_pins(mux), {p1_oe, p1_out & p1_oe, p0_oe, p0_out & p0_oe});
  endtask

  task automatic complete_run;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ==========================================================
  // register bus and sequencing
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    addr <= a;
    wdat <= d;
    wr_s <= 1'b1;
    @(posedge i_ref_clk);
    wr_s <= 1'b0;
    case (a)
      PORT0_LATCH_OFS: l0 = d;
      PORT1_LATCH_OFS: l1 = d;
      PORT0_DIR_OFS:   d0 = acc ? 8'h00 : d;
      PORT1_DIR_OFS:   d1 = d;
      PORT1_FSEL_OFS:  fs = d;
      default:         ;
    endcase
  endtask

  task automatic rd(input logic [31:0] a, output logic [7:0] d);
    @(posedge i_ref_clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge i_ref_clk);
    rd_s <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask

  task automatic do_reset(input logic s);
    @(posedge i_ref_clk);
    i_rst <= 1'b1;
    strap <= s;
    {acc, drv, aph} <= 3'b000;
    repeat (16) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    {l0, l1, d0, d1, fs} = '0;
    settle(2);
  endtask

  initial
  begin
    repeat (20000) @(posedge i_ref_clk);
    mismatches++;
    complete_run();
  end

  initial
  begin
    e = $urandom(50259);
    do_reset(1'b0);
    check("bus_mode", 32'h0, {31'h0, bus_mode});
    rd(PORT0_DIR_OFS, v);  check("p0_dir", DIR_RST, v);
    rd(PORT1_DIR_OFS, v);  check("p1_dir", DIR_RST, v);
    rd(PORT1_FSEL_OFS, v); check("p1_fsel", FSEL_RST, v);
    check_pins(1'b0);
    wr(PORT0_DIR_OFS, 8'hff);
    wr(PORT1_DIR_OFS, 8'hff);
    rd(PORT0_LATCH_OFS, v); check("p0_latch", LATCH_RST, v);
    rd(PORT1_LATCH_OFS, v); check("p1_latch", LATCH_RST, v);
    settle(1); check_pins(1'b0);
    rd(32'hffff_f003, v); check("unmapped", 32'h0, v);
    for (int k = 0; k < 24; k++)
    begin
      far0     <= 8'($urandom);
      far1     <= 8'($urandom);
      ext_addr <= 16'($urandom);
      wr(PORT0_LATCH_OFS, 8'($urandom));
      wr(PORT1_LATCH_OFS, 8'($urandom));
      wr(PORT0_DIR_OFS, k == 0 ? 8'h0f : 8'($urandom));
      wr(PORT1_DIR_OFS, k == 0 ? 8'haa : 8'($urandom));
      wr(PORT1_FSEL_OFS, k == 0 ? 8'hcc : 8'($urandom));
      settle(1); check_pins(1'b0);
      rd(PORT0_LATCH_OFS, v); check("p0_readback", (l0 & d0) | (far0 & ~d0), v);
      rd(PORT1_LATCH_OFS, v);
      e = exp_pins(1'b0);
      check("p1_readback", e[23:16] | (far1 & ~e[31:24]), v);
    end
    // external write then external read, separate bus
    far_en <= 1'b0;
    acc <= 1'b1;
    drv <= 1'b1;
    ext_wdata <= 16'($urandom);
    d0 = 8'h00;
    settle(2); check_pins(1'b0);
    wr(PORT0_DIR_OFS, 8'hff);
    settle(1); check_pins(1'b0);
    far_en <= 1'b1;
    drv <= 1'b0;
    settle(6); e = exp_pins(1'b0);
    check("ext_rdata", {e[23:16] | (far1 & ~e[31:24]), far0}, ext_rdata);
    acc <= 1'b0;
    settle(2); rd(PORT0_DIR_OFS, v); check("p0_dir_after", 32'h0, v);
    check_pins(1'b0);
    // multiplexed bus from the strap
    do_reset(1'b1);
    check("bus_mode", 32'h1, {31'h0, bus_mode});
    wr(PORT1_FSEL_OFS, 8'hff);
    wr(PORT1_DIR_OFS, 8'h0f);
    acc <= 1'b1;
    aph <= 1'b1;
    ext_addr <= 16'($urandom);
    settle(2); check_pins(1'b1);
    aph <= 1'b0;
    settle(2); check_pins(1'b1);
    do_reset(1'b0);
    check("bus_mode", 32'h0, {31'h0, bus_mode});
    acc <= 1'b1;
    aph <= 1'b1;
    settle(2); check_pins(1'b0);
    complete_run();
  end
endmodule // test_bus_shared_port_pair
